/* File: uiw_cfg.svh */
/*
 Constants for the receiver quiet-line detect and wakeup block.
 Assumes it is included by the package and the design modules by bare name.
*/
`ifndef UIW_CFG_SVH
`define UIW_CFG_SVH

// Quiet length in bit times for the 8-bit and 9-bit data formats
`define UIW_QUIET_LEN_8 4'hA
`define UIW_QUIET_LEN_9 4'hB
// Width of the quiet bit-time counter
`define UIW_QCNT_W 4
// Data width held in the receive data register (8 bits plus ninth bit)
`define UIW_DATA_W 9
// Bit position of the address mark in 7-bit and 8-bit data formats
`define UIW_MARK_POS_7 6
`define UIW_MARK_POS_8 7
// Bit position of the ninth data bit
`define UIW_NINTH_POS 8
// Reset values
`define UIW_QCNT_RST 4'h0
`define UIW_DATA_RST 9'h000
// Buffer entry count
`define UIW_BUF_DEPTH 2

`endif

/* File: uiw_pkg.sv */
/*
 Types for the receiver quiet-line detect and wakeup block.
 Assumes uiw_cfg.svh is on the include path.
*/
`include "uiw_cfg.svh"

package uiw_pkg;

   typedef enum logic [1:0] {
      UIW_AWAKE = 2'b00,
      UIW_SLEEP_QUIET = 2'b01,
      UIW_SLEEP_MARK = 2'b10
   } uiw_mode_t;

   typedef logic [`UIW_DATA_W-1:0] uiw_data_t;

endpackage

/* File: uiw_buf.sv */
/*
 Two-entry valid/ready buffer carrying received characters toward the reader.
 Assumes a single clock, synchronous active-high reset and a clock enable.
*/
`timescale 1ns/10ps
`default_nettype none

`include "uiw_cfg.svh"

module uiw_buf
   import uiw_pkg::*;
(
   input wire logic clock_i, // System clock
   input wire logic rst_i, // Synchronous reset
   input wire logic ce_i, // Clock enable
   input wire logic in_valid_i, // Word offered
   output logic in_ready_o, // Room for a word
   input wire uiw_data_t in_data_i, // Word in
   output logic out_valid_o, // Word available
   input wire logic out_ready_i, // Reader takes word
   output uiw_data_t out_data_o // Oldest word
);

   typedef struct packed {
      uiw_data_t [`UIW_BUF_DEPTH-1:0] mem;
      logic [1:0] cnt;
   } uiw_buf_st_t;

   uiw_buf_st_t st_q;
   uiw_buf_st_t st_d;
   logic push;
   logic pop;

   always_comb begin
      st_d = st_q;
      pop = out_valid_o && out_ready_i;
      push = in_valid_i && (in_ready_o || pop);
      if (pop) begin
         st_d.mem[0] = st_q.mem[1];
      end
      if (push) begin
         // Entry at the count left after any pop
         if (pop) begin
            st_d.mem[st_q.cnt - 2'h1] = in_data_i;
         end else begin
            st_d.mem[st_q.cnt[0]] = in_data_i;
         end
      end
      st_d.cnt = st_q.cnt + {1'b0, push} - {1'b0, pop};
   end

   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         st_q <= '0;
      end else if (ce_i) begin
         st_q <= st_d;
      end
   end

   assign in_ready_o = (st_q.cnt != 2'h2);
   assign out_valid_o = (st_q.cnt != 2'h0);
   assign out_data_o = st_q.mem[0];

endmodule

`default_nettype wire

/* File: uiw_rx_wake.sv */
/*
 Quiet-line detection, receive status flags and sleep/wakeup control of an
 asynchronous serial receiver. Assumes the neighbouring sampler supplies one
 voted bit per bit time and a frame-done pulse with the shifted character,
 all synchronous to clock_i. Status and data reads arrive as one-cycle pulses.
*/
`timescale 1ns/10ps
`default_nettype none

`include "uiw_cfg.svh"

// Functional notes
// - Quiet line needs 10 contiguous one bit times, 11 in nine-bit format.
// - Short detection counts ones anywhere, including inside frames.
// - Long detection starts counting ones only after a stop bit.
// - Quiet flag sets once the line stays quiet long enough.
// - Type select chooses short or long detection.
// - With irq enable set, quiet flag raises an interrupt request.
// - Quiet flag clears on status read seeing it, then data read.
// - After clearing, quiet flag waits for a received frame before setting again.
// - Writing one to sleep bit enters wakeup mode.
// - While asleep no receiver status flag sets, except on the address frame that ends mark sleep.
// - Software may clear sleep bit; hardware clears it on wakeup.
// - Wake method: 0 quiet-line, 1 address mark.
// - Quiet-line wakeup clears sleep bit on detected quiet line.
// - Address frame has data MSB one, after seven, eight or nine data bits.
// - Address frame in mark sleep wakes, loads data, sets full flag.
// - Completed frame loads data and sets full, or overrun if full.
// - Status then data read clears full, overrun, noise, framing and parity flags; quiet flag only if the status read saw it.
module uiw_rx_wake
   import uiw_pkg::*;
(
   input wire logic clock_i, // System clock
   input wire logic rst_i, // Synchronous reset
   input wire logic ce_i, // Clock enable, freezes state when low
   input wire logic bit_tick_i, // One pulse per sampled bit time
   input wire logic bit_val_i, // Voted bit level for this bit time
   input wire logic frame_done_i, // Stop bit complete pulse
   input wire uiw_data_t frame_data_i, // Shifted character, bit 8 ninth bit
   input wire logic frame_noise_i, // Noise seen in frame
   input wire logic frame_ferr_i, // Stop bit sampled low
   input wire logic frame_perr_i, // Parity mismatch
   input wire logic nine_bit_i, // Nine-bit data format
   input wire logic seven_bit_i, // Seven-bit data format, mark in bit 6
   input wire logic quiet_type_select_i, // 0 short, 1 long detection
   input wire logic quiet_irq_enable_i, // Quiet interrupt enable
   input wire logic wake_method_i, // 0 quiet-line, 1 address mark
   input wire logic sleep_set_i, // Write one to sleep bit
   input wire logic sleep_clr_i, // Write zero to sleep bit
   input wire logic status_rd_i, // Status register read pulse
   input wire logic data_rd_i, // Data register read pulse
   output logic [`UIW_DATA_W-1:0] serial_data_reg_o, // Receive data register
   output logic rx_full_flag_o, // Receive full
   output logic quiet_flag_o, // Quiet line seen
   output logic overrun_flag_o, // Overrun
   output logic noise_flag_o, // Noise
   output logic framing_error_flag_o, // Framing error
   output logic parity_error_flag_o, // Parity error
   output logic rx_sleep_bit_o, // Receiver asleep
   output logic quiet_irq_o, // Quiet interrupt request
   output logic stream_valid_o, // Character offered on stream
   input wire logic stream_ready_i, // Stream sink takes character
   output logic [`UIW_DATA_W-1:0] stream_data_o // Stream character
);

   typedef struct packed {
      logic [`UIW_QCNT_W-1:0] qcnt;
      logic counting;
      logic quiet_armed;
      logic clr_armed;
      logic idle_seen;
      uiw_mode_t mode;
      logic [`UIW_DATA_W-1:0] rx_holding_reg;
      logic rx_full_flag;
      logic idle;
      logic ovr;
      logic nf;
      logic fe;
      logic pf;
      logic irq;
      logic sv;
      logic [`UIW_DATA_W-1:0] sdata;
   } uiw_st_t;

   uiw_st_t st_q;
   uiw_st_t st_d;
   logic [`UIW_QCNT_W-1:0] qlen;
   logic quiet_hit;
   logic is_addr;
   logic take;
   logic buf_in_ready;
   logic buf_out_valid;
   uiw_data_t buf_out_data;
   logic buf_in_valid;

   // Holds up to two delivered characters; once it is full, a data read for a stalled stream sink drops its character
   uiw_buf u_buf (
      .clock_i(clock_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .in_valid_i(buf_in_valid),
      .in_ready_o(buf_in_ready),
      .in_data_i(st_q.rx_holding_reg),
      .out_valid_o(buf_out_valid),
      .out_ready_i(!st_q.sv || stream_ready_i),
      .out_data_o(buf_out_data)
   );

   always_comb begin
      st_d = st_q;
      qlen = nine_bit_i ? `UIW_QUIET_LEN_9 : `UIW_QUIET_LEN_8;
      if (nine_bit_i) begin
         is_addr = frame_data_i[`UIW_NINTH_POS];
      end else if (seven_bit_i) begin
         is_addr = frame_data_i[`UIW_MARK_POS_7];
      end else begin
         is_addr = frame_data_i[`UIW_MARK_POS_8];
      end
      quiet_hit = 1'b0;
      take = 1'b0;
      buf_in_valid = 1'b0;

      if (frame_done_i) begin
         st_d.counting = 1'b1;
      end
      if (bit_tick_i) begin
         if (!bit_val_i) begin
            st_d.qcnt = `UIW_QCNT_RST;
            st_d.counting = !quiet_type_select_i;
         end else if (st_q.counting || !quiet_type_select_i) begin
            if (st_q.qcnt != qlen) begin
               st_d.qcnt = st_q.qcnt + 4'h1;
            end
            quiet_hit = (st_q.qcnt + 4'h1 == qlen);
         end
      end

      if (status_rd_i) begin
         st_d.clr_armed = 1'b1;
         // only a read that saw the quiet flag may clear it
         st_d.idle_seen = st_q.idle;
      end
      if (data_rd_i && st_q.clr_armed) begin
         st_d.clr_armed = 1'b0;
         st_d.rx_full_flag = 1'b0;
         if (st_q.idle_seen) begin
            st_d.idle = 1'b0;
         end
         st_d.idle_seen = 1'b0;
         st_d.ovr = 1'b0;
         st_d.nf = 1'b0;
         st_d.fe = 1'b0;
         st_d.pf = 1'b0;
      end

      if (sleep_set_i) begin
         st_d.mode = wake_method_i ? UIW_SLEEP_MARK : UIW_SLEEP_QUIET;
      end else if (sleep_clr_i) begin
         st_d.mode = UIW_AWAKE;
      end

      case (st_q.mode)
         UIW_AWAKE: begin
            // quiet flag set wins over clear
            if (quiet_hit && st_q.quiet_armed) begin
               st_d.idle = 1'b1;
               st_d.quiet_armed = 1'b0;
            end
            take = frame_done_i;
         end
         UIW_SLEEP_QUIET: begin
            // wake on quiet line, flags inhibited
            if (quiet_hit) begin
               st_d.mode = UIW_AWAKE;
            end
         end
         UIW_SLEEP_MARK: begin
            if (frame_done_i && is_addr) begin
               st_d.mode = UIW_AWAKE;
               take = 1'b1;
            end
         end
         default: begin
            st_d.mode = UIW_AWAKE;
         end
      endcase

      if (take) begin
         if (st_q.rx_full_flag) begin
            st_d.ovr = 1'b1;
         end else begin
            st_d.rx_holding_reg = frame_data_i;
            st_d.rx_full_flag = 1'b1;
            st_d.nf = frame_noise_i;
            st_d.fe = frame_ferr_i;
            st_d.pf = frame_perr_i;
            // a received frame re-arms quiet detection
            st_d.quiet_armed = 1'b1;
         end
      end
      // New full flag is a fresh event, keep clear arm from reading stale status
      if (take && !st_q.rx_full_flag) begin
         st_d.clr_armed = 1'b0;
      end

      // Copy to stream buffer on each data read while the full flag is set and the buffer has room
      buf_in_valid = data_rd_i && st_q.rx_full_flag && buf_in_ready;
      if (!st_q.sv || stream_ready_i) begin
         st_d.sv = buf_out_valid;
         st_d.sdata = buf_out_data;
      end

      st_d.irq = quiet_irq_enable_i && st_d.idle;
   end

   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         st_q <= '0;
      end else if (ce_i) begin
         st_q <= st_d;
      end
   end

   assign serial_data_reg_o = st_q.rx_holding_reg;
   assign rx_full_flag_o = st_q.rx_full_flag;
   assign quiet_flag_o = st_q.idle;
   assign overrun_flag_o = st_q.ovr;
   assign noise_flag_o = st_q.nf;
   assign framing_error_flag_o = st_q.fe;
   assign parity_error_flag_o = st_q.pf;
   assign rx_sleep_bit_o = (st_q.mode != UIW_AWAKE);
   assign quiet_irq_o = st_q.irq;
   assign stream_valid_o = st_q.sv;
   assign stream_data_o = st_q.sdata;

endmodule

`default_nettype wire

/* File: uiw_chk.sv */
/*
 Port-level assertions for uiw_rx_wake, bound to every instance.
 Assumes one clock domain; checks are suspended while ce_i is low.
*/
`timescale 1ns/10ps
`default_nettype none
`include "uiw_cfg.svh"
module uiw_chk
   import uiw_pkg::*;
(
   input wire logic clock_i, // Clock
   input wire logic rst_i, // Reset
   input wire logic ce_i, // Clock enable
   input wire logic bit_tick_i, // Tick
   input wire logic bit_val_i, // Level
   input wire logic frame_done_i, // Frame end
   input wire uiw_data_t frame_data_i, // Char
   input wire logic nine_bit_i, // 9-bit
   input wire logic quiet_type_select_i, // Type
   input wire logic quiet_irq_enable_i, // Irq enable
   input wire logic sleep_set_i, // Sleep set
   input wire logic sleep_clr_i, // Sleep clear
   input wire logic status_rd_i, // Status read
   input wire logic data_rd_i, // Data read
   input wire logic [`UIW_DATA_W-1:0] serial_data_reg_o, // Data reg
   input wire logic rx_full_flag_o, // Full
   input wire logic quiet_flag_o, // Quiet
   input wire logic overrun_flag_o, // Overrun
   input wire logic rx_sleep_bit_o, // Asleep
   input wire logic quiet_irq_o // Irq
);
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (rst_i || !ce_i);
   logic [3:0] ones_q;
   // Saturates so a long quiet line never wraps into a false count
   always_ff @(posedge clock_i) begin
      if (rst_i)
         ones_q <= 4'h0;
      else if (ce_i && bit_tick_i)
         ones_q <= bit_val_i ? ones_q + {3'h0, ones_q != 4'hF} : 4'h0;
   end
   sequence s_take;
      data_rd_i && !frame_done_i && !bit_tick_i;
   endsequence
   AST_QUIET_LEN: assert property ($rose(quiet_flag_o) && !quiet_type_select_i |->
      ones_q == (nine_bit_i ? 4'hB : 4'hA)) else $error("quiet length wrong");
   AST_IRQ: assert property (quiet_irq_o == ($past(quiet_irq_enable_i) && quiet_flag_o))
      else $error("quiet irq wrong");
   AST_SLEEP_SET: assert property (sleep_set_i |=> rx_sleep_bit_o)
      else $error("sleep not entered");
   AST_SLEEP_CLR: assert property (sleep_clr_i && !sleep_set_i |=> !rx_sleep_bit_o)
      else $error("sleep not left");
   AST_LOAD: assert property (frame_done_i && !rx_full_flag_o && !rx_sleep_bit_o |=>
      rx_full_flag_o && serial_data_reg_o == $past(frame_data_i)) else $error("load wrong");
   AST_OVR: assert property (frame_done_i && rx_full_flag_o && !rx_sleep_bit_o && !data_rd_i |=>
      overrun_flag_o && $stable(serial_data_reg_o)) else $error("overrun wrong");
   AST_QUIET_CLR: assert property (status_rd_i && quiet_flag_o ##1 s_take |=> !quiet_flag_o)
      else $error("quiet not cleared");
   AST_ALL_CLR: assert property (status_rd_i && rx_full_flag_o ##1 s_take |=>
      !rx_full_flag_o && !overrun_flag_o) else $error("flags not cleared");
   AST_ASLEEP: assert property ($rose(quiet_flag_o) || $rose(overrun_flag_o) |->
      !$past(rx_sleep_bit_o)) else $error("flag set while asleep");
   AST_DISCARD: assert property (rx_sleep_bit_o && frame_done_i && frame_data_i[8:6] == 3'h0
      && !sleep_clr_i && !rx_full_flag_o |=> !rx_full_flag_o) else $error("data frame kept");
endmodule
bind uiw_rx_wake uiw_chk u_uiw_chk (.clock_i, .rst_i, .ce_i, .bit_tick_i, .bit_val_i, .frame_done_i,
   .frame_data_i, .nine_bit_i, .quiet_type_select_i, .quiet_irq_enable_i, .sleep_set_i,
   .sleep_clr_i, .status_rd_i, .data_rd_i, .serial_data_reg_o, .rx_full_flag_o, .quiet_flag_o,
   .overrun_flag_o, .rx_sleep_bit_o, .quiet_irq_o);
`default_nettype wire

/* File: uiw_tx_model.sv */
/*
 Remote transmitter seen through the bit sampler: bit ticks and frames.
 Assumes the bench calls its tasks from one process.
*/
`timescale 1ns/10ps
`default_nettype none
module uiw_tx_model
   import uiw_pkg::*;
(
   input wire logic clock_i, // Clock
   output logic bit_tick_o, // Bit time
   output logic bit_val_o, // Level
   output logic frame_done_o, // Stop done
   output uiw_data_t frame_data_o // Char
);
   int gap = 2;
   initial begin
      bit_tick_o = 1'h0;
      bit_val_o = 1'h1;
      frame_done_o = 1'h0;
      frame_data_o = '0;
   end
   task automatic put_bit(input logic v);
      repeat (gap) @(posedge clock_i);
      bit_tick_o <= 1'h1;
      bit_val_o <= v;
      @(posedge clock_i);
      bit_tick_o <= 1'h0;
      // Level is only meaningful with a tick, so show a wrong one between
      bit_val_o <= !v;
   endtask
   task automatic quiet(input int n);
      repeat (n) put_bit(1'h1);
   endtask
   task automatic send(input uiw_data_t d, input int n);
      put_bit(1'h0);
      for (int i = 0; i < n; i++) put_bit(d[i]);
      put_bit(1'h1);
      @(posedge clock_i);
      frame_done_o <= 1'h1;
      frame_data_o <= d;
      @(posedge clock_i);
      frame_done_o <= 1'h0;
      frame_data_o <= ~d;
   endtask
endmodule
`default_nettype wire

/* File: test_uiw_rx_wake.sv */
/*
 Self-checking bench for uiw_rx_wake driven by the transmitter model.
 Assumes the model's tasks are called from the one initial process.
*/
`timescale 1ns/10ps
`default_nettype none
`include "uiw_cfg.svh"
`define CHK(a, b) begin \
   samples_checked++; \
   if ((a) !== (b)) begin \
      fail_count++; \
      $display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); \
   end \
end
module test_uiw_rx_wake;
   logic clock_i = 1'h0;
   logic rst_i = 1'h1;
   logic nine = 1'h0;
   logic seven = 1'h0;
   logic qtype = 1'h0;
   logic qie = 1'h0;
   logic wake = 1'h0;
   logic sset = 1'h0;
   logic sclr = 1'h0;
   logic srd = 1'h0;
   logic drd = 1'h0;
   logic sready = 1'h0;
   logic ce = 1'h1;
   logic [2:0] ferr_in = 3'h0; // Noise, framing, parity
   logic tick, bval, done, full, qflag, ovr, slp, irq, svld, nfl, fefl, pfl;
   uiw_pkg::uiw_data_t fdata;
   logic [`UIW_DATA_W-1:0] dreg, sdata;
   int fail_count = 0;
   int samples_checked = 0;
   int cyc = 0;
   uiw_tx_model u_uiw_tx_model (.clock_i(clock_i), .bit_tick_o(tick), .bit_val_o(bval),
      .frame_done_o(done), .frame_data_o(fdata));
   uiw_rx_wake u_uiw_rx_wake (.clock_i(clock_i), .rst_i(rst_i), .ce_i(ce), .bit_tick_i(tick),
      .bit_val_i(bval), .frame_done_i(done), .frame_data_i(fdata), .frame_noise_i(ferr_in[2]),
      .frame_ferr_i(ferr_in[1]), .frame_perr_i(ferr_in[0]), .nine_bit_i(nine), .seven_bit_i(seven),
      .quiet_type_select_i(qtype), .quiet_irq_enable_i(qie), .wake_method_i(wake),
      .sleep_set_i(sset), .sleep_clr_i(sclr), .status_rd_i(srd), .data_rd_i(drd),
      .serial_data_reg_o(dreg), .rx_full_flag_o(full), .quiet_flag_o(qflag),
      .overrun_flag_o(ovr), .noise_flag_o(nfl), .framing_error_flag_o(fefl), .parity_error_flag_o(pfl),
      .rx_sleep_bit_o(slp), .quiet_irq_o(irq), .stream_valid_o(svld),
      .stream_ready_i(sready), .stream_data_o(sdata));
   always #5 clock_i = !clock_i;
   task give_verdict();
      if (fail_count == 0 && samples_checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // The run needs about 600 cycles; the ceiling leaves wide margin
   always @(posedge clock_i) begin
      cyc++;
      if (cyc == 20000) begin
         fail_count++;
         give_verdict();
      end
   end
   task tk(input int n);
      repeat (n) @(posedge clock_i);
      #1;
   endtask
   task rd_clear();
      @(posedge clock_i) srd <= 1'h1;
      @(posedge clock_i) srd <= 1'h0;
      drd <= 1'h1;
      @(posedge clock_i) drd <= 1'h0;
      #1;
   endtask
   task go_sleep(input logic m);
      @(posedge clock_i) wake <= m;
      sset <= 1'h1;
      @(posedge clock_i) sset <= 1'h0;
      #1;
   endtask
   initial begin
      repeat (10) @(posedge clock_i);
      rst_i <= 1'h0;
      qie <= 1'h1;
      u_uiw_tx_model.quiet(12);
      tk(0);
      `CHK({full, qflag, slp, svld}, 4'h0)
      u_uiw_tx_model.send(9'h0FF, 8);
      tk(0);
      `CHK({full, qflag, dreg}, {2'h2, 9'h0FF})
      u_uiw_tx_model.quiet(1);
      tk(0);
      `CHK({qflag, irq}, 2'h3)
      u_uiw_tx_model.send(9'h011, 8);
      tk(0);
      `CHK({ovr, dreg}, {1'h1, 9'h0FF})
      rd_clear();
      `CHK({full, qflag, ovr, irq}, 4'h0)
      u_uiw_tx_model.quiet(12);
      tk(1);
      `CHK({qflag, svld, sdata}, {2'h1, 9'h0FF})
      @(posedge clock_i) qtype <= 1'h1;
      u_uiw_tx_model.send(9'h0F0, 8);
      u_uiw_tx_model.quiet(9);
      tk(0);
      `CHK(qflag, 1'h0)
      u_uiw_tx_model.quiet(1);
      tk(0);
      `CHK(qflag, 1'h1)
      rd_clear();
      @(posedge clock_i) qtype <= 1'h0;
      u_uiw_tx_model.send(9'h07F, 8);
      u_uiw_tx_model.quiet(5);
      u_uiw_tx_model.put_bit(1'h0);
      u_uiw_tx_model.quiet(9);
      tk(0);
      `CHK(qflag, 1'h0)
      u_uiw_tx_model.quiet(1);
      tk(0);
      `CHK(qflag, 1'h1)
      rd_clear();
      // Stream holds three words: one staged at the output, two in the buffer
      @(posedge clock_i) sready <= 1'h1;
      tk(0);
      `CHK({svld, sdata}, {1'h1, 9'h0FF})
      tk(1);
      `CHK({svld, sdata}, {1'h1, 9'h0F0})
      tk(1);
      `CHK({svld, sdata}, {1'h1, 9'h07F})
      tk(1);
      `CHK(svld, 1'h0)
      @(posedge clock_i) nine <= 1'h1;
      u_uiw_tx_model.gap = 5;
      u_uiw_tx_model.send(9'h1FF, 9);
      tk(0);
      `CHK({qflag, dreg}, {1'h0, 9'h1FF})
      u_uiw_tx_model.quiet(1);
      tk(0);
      `CHK(qflag, 1'h1)
      rd_clear();
      u_uiw_tx_model.gap = 1;
      @(posedge clock_i) nine <= 1'h0;
      go_sleep(1'h1);
      u_uiw_tx_model.send(9'h055, 8);
      u_uiw_tx_model.quiet(12);
      tk(0);
      `CHK({slp, full, dreg}, {2'h2, 9'h1FF})
      u_uiw_tx_model.send(9'h0C3, 8);
      tk(0);
      `CHK({slp, full, dreg}, {2'h1, 9'h0C3})
      rd_clear();
      @(posedge clock_i) seven <= 1'h1;
      go_sleep(1'h1);
      u_uiw_tx_model.send(9'h03F, 7);
      tk(0);
      `CHK({slp, full}, 2'h2)
      u_uiw_tx_model.send(9'h040, 7);
      tk(0);
      `CHK({slp, full, dreg}, {2'h1, 9'h040})
      rd_clear();
      @(posedge clock_i) seven <= 1'h0;
      go_sleep(1'h0);
      `CHK(slp, 1'h1)
      u_uiw_tx_model.send(9'h055, 8);
      u_uiw_tx_model.quiet(8);
      tk(0);
      `CHK({slp, full}, 2'h2)
      u_uiw_tx_model.quiet(1);
      tk(0);
      `CHK({slp, full, qflag}, 3'h0)
      go_sleep(1'h1);
      @(posedge clock_i) sclr <= 1'h1;
      @(posedge clock_i) sclr <= 1'h0;
      tk(0);
      `CHK(slp, 1'h0)
      // Error levels ride with the frame; a frozen clock enable must hold them
      @(posedge clock_i) ferr_in <= 3'h7;
      u_uiw_tx_model.send(9'h0AA, 8);
      tk(0);
      `CHK({full, nfl, fefl, pfl, dreg}, {4'hF, 9'h0AA})
      @(posedge clock_i) ferr_in <= 3'h0;
      ce <= 1'h0;
      rd_clear();
      `CHK({full, nfl, fefl, pfl}, 4'hF)
      @(posedge clock_i) ce <= 1'h1;
      rd_clear();
      `CHK({full, nfl, fefl, pfl, ovr}, 5'h00)
      give_verdict();
   end
endmodule
`default_nettype wire
